// File: design/config_loader.sv
/*
  Master-mode configuration loader: reads the bitstream from one or two
  serial NOR flashes, forwards chain data in x1 width and delivers own bytes.
  Assumes clk_sys at 100 MHz, flash pins resolved by the board from the
  output enables, and an APB master for the control registers.
*/
// The APB slave port and the placing of the registers were chosen for this implementation.
// Contract
// RQ1 - low reset clears all loader state
// RQ2 - mode pins 001 select flash master
// RQ3 - low init flag postpones configuration
// RQ4 - init flag driven low on error
// RQ5 - primary flash select low while fetching
// RQ6 - secondary flash select in x8 width
// RQ7 - chain output changes on falling clock edge
// RQ8 - done pin low until configuration completes
// RQ9 - loading starts at power-up or reset
// RQ10 - start x1 fast read, address zero, rising
// RQ11 - mode instruction sets width and edge
// RQ12 - selects high when bitstream fully fetched
// RQ13 - above 15.38MHz sample on falling edge
// RQ14 - configuration clock generated internally
// RQ15 - widths 1, 2, 4 and 8 bits
// RQ16 - x1: line 0 out, line 1 in
// RQ17 - x2 uses data lines 1..0
// RQ18 - x4 uses data lines 3..0
// RQ19 - x8: lines 3..0 first, 7..4 second
// RQ20 - first device master, rest fed serially
// RQ21 - chain image holds last device first
// RQ22 - mode pins sampled once after init release
`include "config_loader_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module config_loader #(
  parameter logic [7:0] HALF_DEFAULT = `CL_HALF_DEF,
  parameter logic [23:0] LEN_DEFAULT = `CL_LEN_DEF
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire config_loader_pkg::apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] mode_pins,
  input wire logic init_flag_in,
  output logic init_flag_out,
  output logic init_flag_oe_n,
  input wire logic cfg_done_in,
  output logic cfg_done_out,
  output logic cfg_done_oe_n,
  output logic cfg_clk_out,
  output logic flash_select_a_n,
  output logic flash_select_b_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe_n,
  output logic chain_data_out,
  output logic [7:0] cfg_byte,
  output logic cfg_byte_valid
);

  ////////////////////////////////////////////////////////////////////////
  // parameter checks

  if (HALF_DEFAULT < `CL_HALF_MIN) begin : g_half_chk
    $error("half period default below synchroniser limit");
  end
  if (LEN_DEFAULT == 24'h000000) begin : g_len_chk
    $error("bitstream length default must be nonzero");
  end

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // bits gathered per sampling edge for a width code
  function automatic logic [3:0] width_bits(input logic [1:0] w);
    case (w)
      config_loader_pkg::W_X1: width_bits = 4'h1;
      config_loader_pkg::W_X2: width_bits = 4'h2;
      config_loader_pkg::W_X4: width_bits = 4'h4;
      default: width_bits = 4'h8;
    endcase
  endfunction

  // clock faster than the rising-edge limit for this half period
  function automatic logic is_fast(input logic [7:0] h);
    is_fast = (`CL_SYS_KHZ) > (`CL_EDGE_LIMIT_KHZ * 2 * int'(h));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    config_loader_pkg::phase_t phase;
    logic [2:0] mode_s1;
    logic [2:0] mode_s2;
    logic init_s1;
    logic init_s2;
    logic done_s1;
    logic done_s2;
    logic [7:0] din_s1;
    logic [7:0] din_s2;
    logic [2:0] mode_cap;
    logic [7:0] half_q;
    logic [23:0] len_q;
    logic [23:0] chain_len_q;
    logic [7:0] half_cnt;
    logic clk_lvl;
    logic [5:0] bit_cnt;
    logic [39:0] shift;
    logic [7:0] rx;
    logic [3:0] rx_cnt;
    logic [23:0] byte_addr;
    logic [23:0] chain_cnt;
    logic [23:0] own_cnt;
    logic [1:0] width;
    logic edge_fall;
    logic pend_mode;
    logic mode_seen;
    logic chain_pend;
    logic chain_q;
    logic sel_a;
    logic sel_b;
    logic [7:0] byte_q;
    logic byte_v;
    logic [31:0] prdata_q;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic rise;
  logic fall;
  logic samp;
  logic access;
  logic setup;
  logic [3:0] nb;
  logic [7:0] bits;
  logic [7:0] nxt_rx;
  logic [3:0] nxt_cnt;
  logic [7:0] op;
  config_loader_pkg::status_t stat;

  assign access = apb_req.psel && apb_req.penable;
  assign setup = apb_req.psel && !apb_req.penable;

  // clock edges: counter reaches zero while the clock runs
  assign rise = (s_q.phase == config_loader_pkg::P_CMD ||
                 s_q.phase == config_loader_pkg::P_DATA) &&
                s_q.half_cnt == 8'h00 && !s_q.clk_lvl;
  assign fall = (s_q.phase == config_loader_pkg::P_CMD ||
                 s_q.phase == config_loader_pkg::P_DATA) &&
                s_q.half_cnt == 8'h00 && s_q.clk_lvl;
  // sampling edge chosen by the mode instruction or the clock rate
  assign samp = s_q.edge_fall ? fall : rise; // see RQ13

  always_comb begin
    stat = '0;
    stat.phase = s_q.phase;
    stat.width = config_loader_pkg::width_t'(s_q.width);
    stat.edge_fall = s_q.edge_fall;
    stat.mode_pins = s_q.mode_cap;
    stat.init_pin = s_q.init_s2;
    stat.cfg_done_pin = s_q.done_s2;
  end

  // incoming lines per width; x8 puts second flash in high nibble
  always_comb begin
    nb = width_bits(s_q.width); // see RQ15
    case (s_q.width)
      config_loader_pkg::W_X1: bits = {7'h00, s_q.din_s2[1]}; // see RQ16
      config_loader_pkg::W_X2: bits = {6'h00, s_q.din_s2[1:0]}; // see RQ17
      config_loader_pkg::W_X4: bits = {4'h0, s_q.din_s2[3:0]}; // see RQ18
      default: bits = s_q.din_s2; // see RQ19
    endcase
    // older bits move up by the width, new bits land at the bottom
    nxt_rx = 8'({s_q.rx, 8'h00} >> (4'h8 - nb)) | bits;
    nxt_cnt = s_q.rx_cnt + nb;
    // command opcode follows width; x8 runs both flashes in quad
    case (s_q.width)
      config_loader_pkg::W_X1: op = `CL_OP_X1;
      config_loader_pkg::W_X2: op = `CL_OP_X2;
      default: op = `CL_OP_X4;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_d = s_q;
    s_d.byte_v = 1'b0;
    // two-stage synchronisers for all pins
    s_d.mode_s1 = mode_pins;
    s_d.mode_s2 = s_q.mode_s1;
    s_d.init_s1 = init_flag_in;
    s_d.init_s2 = s_q.init_s1;
    s_d.done_s1 = cfg_done_in;
    s_d.done_s2 = s_q.done_s1;
    s_d.din_s1 = data_in;
    s_d.din_s2 = s_q.din_s1;

    // register writes; reads are latched in the setup phase
    if (access && apb_req.pwrite) begin
      if (apb_req.paddr == `CL_A_CLK) begin
        if (apb_req.pwdata[7:0] >= `CL_HALF_MIN) begin
          s_d.half_q = apb_req.pwdata[7:0];
        end
      end else if (apb_req.paddr == `CL_A_LEN) begin
        s_d.len_q = apb_req.pwdata[23:0];
      end else if (apb_req.paddr == `CL_A_CHAIN) begin
        s_d.chain_len_q = apb_req.pwdata[23:0];
      end
    end
    if (setup) begin
      if (apb_req.paddr == `CL_A_CLK) begin
        s_d.prdata_q = {24'h000000, s_q.half_q};
      end else if (apb_req.paddr == `CL_A_LEN) begin
        s_d.prdata_q = {8'h00, s_q.len_q};
      end else if (apb_req.paddr == `CL_A_CHAIN) begin
        s_d.prdata_q = {8'h00, s_q.chain_len_q};
      end else if (apb_req.paddr == `CL_A_STAT) begin
        s_d.prdata_q = stat;
      end else if (apb_req.paddr == `CL_A_COUNT) begin
        s_d.prdata_q = {8'h00, s_q.own_cnt};
      end else begin
        s_d.prdata_q = 32'h00000000;
      end
    end

    // internal divider makes the flash clock
    if (s_q.phase == config_loader_pkg::P_CMD ||
        s_q.phase == config_loader_pkg::P_DATA) begin
      if (s_q.half_cnt == 8'h00) begin
        s_d.half_cnt = s_q.half_q - 8'h01; // see RQ14
        s_d.clk_lvl = !s_q.clk_lvl;
      end else begin
        s_d.half_cnt = s_q.half_cnt - 8'h01;
      end
    end

    // chain bit goes out only on the falling edge
    if (fall) begin
      s_d.chain_q = s_q.chain_pend; // see RQ7
    end

    case (s_q.phase)
      config_loader_pkg::P_WAIT: begin
        // held here while the init flag is pulled low outside
        if (s_q.init_s2) begin // see RQ3
          s_d.mode_cap = s_q.mode_s2; // see RQ22
          if (s_q.mode_s2 == `CL_MODE_MASTER) begin // see RQ2
            // x1 fast read from address zero, rising edge
            s_d.phase = config_loader_pkg::P_CMD; // see RQ10
            s_d.shift = {`CL_OP_X1, 24'h000000, 8'h00};
            s_d.sel_a = 1'b1; // see RQ5
            s_d.half_cnt = s_q.half_q - 8'h01;
          end else begin
            s_d.phase = config_loader_pkg::P_OFF;
          end
        end
      end
      config_loader_pkg::P_CMD: begin
        if (rise) begin
          s_d.bit_cnt = s_q.bit_cnt + 6'h01;
        end
        if (fall) begin
          if (s_q.bit_cnt == `CL_CMD_BITS) begin
            s_d.phase = config_loader_pkg::P_DATA;
          end else begin
            s_d.shift = {s_q.shift[38:0], 1'b0};
          end
        end
      end
      config_loader_pkg::P_DATA: begin
        if (samp) begin
          s_d.rx = nxt_rx;
          s_d.rx_cnt = nxt_cnt;
          // chain region in x1: each bit is passed straight on
          if (s_q.mode_seen && s_q.chain_cnt != s_q.chain_len_q) begin
            s_d.chain_pend = bits[0]; // see RQ20
          end
          if (nxt_cnt[3]) begin
            s_d.rx_cnt = 4'h0;
            s_d.byte_addr = s_q.byte_addr + 24'h000001;
            if (!s_q.mode_seen) begin
              if (s_q.pend_mode) begin
                // settings byte: width code and edge request
                s_d.width = nxt_rx[1:0]; // see RQ11
                s_d.edge_fall = nxt_rx[2] || is_fast(s_q.half_q);
                s_d.mode_seen = 1'b1;
                s_d.phase = config_loader_pkg::P_GAP;
                s_d.sel_a = 1'b0;
                s_d.half_cnt = `CL_GAP_CYC;
              end else if (nxt_rx == `CL_MODE_OPC) begin
                s_d.pend_mode = 1'b1;
              end else if (s_q.byte_addr == `CL_MODE_WIN) begin
                // no mode instruction where expected
                s_d.phase = config_loader_pkg::P_ERR;
                s_d.sel_a = 1'b0;
              end
            end else if (s_q.chain_cnt != s_q.chain_len_q) begin
              // image holds far devices first
              s_d.chain_cnt = s_q.chain_cnt + 24'h000001; // see RQ21
            end else begin
              s_d.byte_q = nxt_rx;
              s_d.byte_v = 1'b1;
              s_d.own_cnt = s_q.own_cnt + 24'h000001;
              if (s_q.own_cnt + 24'h000001 == s_q.len_q) begin
                s_d.phase = config_loader_pkg::P_DONE;
                s_d.sel_a = 1'b0; // see RQ12
                s_d.sel_b = 1'b0;
              end
            end
          end
        end
        // park the clock low as the frame ends; a deselected flash
        // must never see it sitting high through the gap
        if (s_d.phase != config_loader_pkg::P_DATA) begin
          s_d.clk_lvl = 1'b0; // see RQ14
        end
      end
      config_loader_pkg::P_GAP: begin
        // flash deselected, then read resumes at the new width
        if (s_q.half_cnt == 8'h00) begin
          s_d.phase = config_loader_pkg::P_CMD;
          s_d.shift = {op, s_q.byte_addr, 8'h00};
          s_d.bit_cnt = 6'h00;
          s_d.clk_lvl = 1'b0;
          s_d.sel_a = 1'b1;
          s_d.sel_b = s_q.width == config_loader_pkg::W_X8; // see RQ6
          s_d.half_cnt = s_q.half_q - 8'h01;
        end else begin
          s_d.half_cnt = s_q.half_cnt - 8'h01;
        end
      end
      default: begin
        s_d.clk_lvl = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // registers: reset restarts loading from the top

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin // see RQ1
      s_q <= '0; // see RQ9
      s_q.phase <= config_loader_pkg::P_WAIT;
      s_q.half_q <= HALF_DEFAULT;
      s_q.len_q <= LEN_DEFAULT;
      s_q.chain_len_q <= `CL_CHAIN_DEF;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = s_q.prdata_q;
  assign pready = 1'b1;
  // unmapped addresses answer with an error
  assign pslverr = access && apb_req.paddr != `CL_A_CLK &&
                   apb_req.paddr != `CL_A_LEN &&
                   apb_req.paddr != `CL_A_CHAIN &&
                   apb_req.paddr != `CL_A_STAT &&
                   apb_req.paddr != `CL_A_COUNT;

  // open drain flag pulled low only on error
  assign init_flag_out = 1'b0;
  assign init_flag_oe_n = s_q.phase != config_loader_pkg::P_ERR; // see RQ4
  assign cfg_done_out = 1'b0;
  assign cfg_done_oe_n = s_q.phase == config_loader_pkg::P_DONE; // see RQ8

  assign cfg_clk_out = s_q.clk_lvl;
  assign flash_select_a_n = !s_q.sel_a;
  assign flash_select_b_n = !s_q.sel_b;

  // command bit on line 0, and line 4 too for the second flash
  assign data_out = {3'h0, s_q.shift[39], 3'h0, s_q.shift[39]};
  assign data_oe_n = {3'h7,
                      !(s_q.phase == config_loader_pkg::P_CMD && s_q.sel_b),
                      3'h7,
                      s_q.phase != config_loader_pkg::P_CMD}; // see RQ16

  assign chain_data_out = s_q.chain_q;
  assign cfg_byte = s_q.byte_q;
  assign cfg_byte_valid = s_q.byte_v;

endmodule

`default_nettype wire

// File: shared/config_loader_defs.svh
/*
  Constants of the serial flash configuration loader: register offsets,
  reset values, flash opcodes and timing counts.
  Assumes inclusion by bare name from design and bench files.
*/
`ifndef CONFIG_LOADER_DEFS_SVH
`define CONFIG_LOADER_DEFS_SVH

`define CL_SYS_KHZ 100000
`define CL_EDGE_LIMIT_KHZ 15380
`define CL_HALF_DEF 8'h04
`define CL_HALF_MIN 8'h02
`define CL_MODE_MASTER 3'b001
`define CL_OP_X1 8'h0b
`define CL_OP_X2 8'h3b
`define CL_OP_X4 8'h6b
`define CL_MODE_OPC 8'h5a
`define CL_CMD_BITS 6'h28
`define CL_GAP_CYC 8'h08
`define CL_MODE_WIN 24'h000010
`define CL_LEN_DEF 24'h001000
`define CL_CHAIN_DEF 24'h000000
`define CL_A_CLK 12'h000
`define CL_A_LEN 12'h004
`define CL_A_CHAIN 12'h008
`define CL_A_STAT 12'h00c
`define CL_A_COUNT 12'h010

`endif

// File: shared/config_loader_pkg.sv
/*
  Types of the serial flash configuration loader.
  Assumes the constants header is compiled alongside.
*/
package config_loader_pkg;

  // loader phases, gray along wait, command, data, gap, done
  typedef enum logic [2:0] {
    P_WAIT = 3'b000,
    P_CMD = 3'b001,
    P_DATA = 3'b011,
    P_GAP = 3'b010,
    P_DONE = 3'b110,
    P_ERR = 3'b111,
    P_OFF = 3'b100
  } phase_t;

  typedef enum logic [1:0] {
    W_X1 = 2'h0,
    W_X2 = 2'h1,
    W_X4 = 2'h2,
    W_X8 = 2'h3
  } width_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // status word, low bits first from the right
  typedef struct packed {
    logic [20:0] zero;
    logic cfg_done_pin;
    logic init_pin;
    logic [2:0] mode_pins;
    logic edge_fall;
    width_t width;
    phase_t phase;
  } status_t;

endpackage

// File: dv/flash_model.sv
/*
  Behavioural serial NOR flash for the loader bench.
  Assumes x1 traffic from one device; image bytes given msb-first.
*/
`timescale 1ns/10ps
`default_nettype none

module flash_model (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic [55:0] img,
  output logic so,
  output logic [31:0] first_cmd,
  output logic [31:0] last_cmd
);
  logic [31:0] sh;
  logic [7:0] bv;
  int n_rise;
  int n_cmd;
  int bi;
  int ba;

  initial begin
    so = 1'b1;
    n_cmd = 0;
  end
  // a new frame restarts the bit count
  always @(negedge cs_n) n_rise = 0;
  // opcode and address shift in on rising clock
  always @(posedge sck) begin
    if (!cs_n) begin
      if (n_rise < 32) sh = {sh[30:0], si};
      n_rise++;
      if (n_rise == 32) begin
        n_cmd++;
        last_cmd = sh;
        if (n_cmd == 1) first_cmd = sh;
      end
    end
  end
  // data on falling clock; undriven line toggles so a stale bit never helps
  always @(negedge sck or posedge cs_n) begin
    bi = n_rise - 40;
    if (cs_n || bi < 0) so = ~so;
    else begin
      ba = last_cmd[23:0] + bi / 8;
      bv = ba < 7 ? img[55 - 8 * ba -: 8] : 8'hff;
      so = bv[7 - bi % 8];
    end
  end
endmodule

`default_nettype wire

// File: dv/config_loader_monitor.sv
/*
  Port checker for the configuration loader.
  Assumes one clock domain; bound by the statement at the foot.
*/
`timescale 1ns/10ps
`default_nettype none

module config_loader_monitor (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire config_loader_pkg::apb_req_t apb_req,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] mode_pins,
  input wire logic init_flag_in,
  input wire logic init_flag_oe_n,
  input wire logic cfg_done_oe_n,
  input wire logic cfg_clk_out,
  input wire logic flash_select_a_n,
  input wire logic flash_select_b_n,
  input wire logic [7:0] data_oe_n,
  input wire logic chain_data_out,
  input wire logic cfg_byte_valid
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  //////////////////////////////////////////////////////////////////////////
  // start and stop of the flash frame
  property p_hold;
    !init_flag_in [*3] |-> flash_select_a_n;
  endproperty
  a_hold: assert property (p_hold)
    else $error("flash selected while init flag held low");
  property p_idle;
    flash_select_a_n && $past(flash_select_a_n) |-> !cfg_clk_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("flash clock runs outside a frame");
  property p_done;
    cfg_done_oe_n |-> flash_select_a_n && flash_select_b_n;
  endproperty
  a_done: assert property (p_done)
    else $error("flash still selected after done");
  property p_stay;
    cfg_done_oe_n |=> cfg_done_oe_n;
  endproperty
  a_stay: assert property (p_stay)
    else $error("done pin pulled low again");
  property p_off;
    mode_pins != 3'b001 [*4] |-> flash_select_a_n && (&data_oe_n);
  endproperty
  a_off: assert property (p_off)
    else $error("flash driven outside master mode");
  property p_err;
    !init_flag_oe_n |=> !init_flag_oe_n && flash_select_a_n;
  endproperty
  a_err: assert property (p_err)
    else $error("error flag released or flash reselected");
  //////////////////////////////////////////////////////////////////////////
  // data lines and cascade output
  property p_chain;
    $changed(chain_data_out) |-> $fell(cfg_clk_out);
  endproperty
  a_chain: assert property (p_chain)
    else $error("cascade bit moved off a falling clock");
  property p_line;
    !data_oe_n[0] |-> !flash_select_a_n && data_oe_n[3:1] == 3'h7;
  endproperty
  a_line: assert property (p_line)
    else $error("command driven on a wrong line or unselected");
  // offsets above 0x010 answer at once with an error
  property p_slverr;
    apb_req.psel && apb_req.penable && apb_req.paddr > 12'h010
      |-> pslverr && pready;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("unmapped access not refused");
endmodule

bind config_loader config_loader_monitor mon (
  .clk_sys, .resetn, .apb_req, .pready, .pslverr, .mode_pins,
  .init_flag_in, .init_flag_oe_n, .cfg_done_oe_n, .cfg_clk_out,
  .flash_select_a_n, .flash_select_b_n, .data_oe_n, .chain_data_out,
  .cfg_byte_valid
);

`default_nettype wire

// File: dv/tb_top.sv
/*
  Self-checking bench of the configuration loader with a flash model.
  Assumes the package, header and checker are compiled before it.
*/
`include "config_loader_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  logic clk_sys, resetn, init_drv, init_flag_in, cfg_done_in, so;
  config_loader_pkg::apb_req_t req;
  logic [31:0] prdata, first_cmd, last_cmd, st;
  logic pready, pslverr, init_flag_oe_n, cfg_done_oe_n, cfg_clk_out;
  logic flash_select_a_n, flash_select_b_n, chain_data_out;
  logic cfg_byte_valid;
  logic [2:0] mode_pins;
  logic [7:0] data_in, data_out, data_oe_n, cfg_byte;
  logic [7:0] rb [0:4];
  logic [55:0] img;
  logic [31:0] expq [$];
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] chain_sh;
  int nr = 0;

  // open-drain pins and flash lines resolved with pull-ups
  assign init_flag_in = init_flag_oe_n ? init_drv : 1'b0;
  assign cfg_done_in = cfg_done_oe_n;
  assign data_in = {6'h3f, so, data_oe_n[0] ? 1'b1 : data_out[0]};

  config_loader #(.LEN_DEFAULT(24'h000004)) dut (
    .clk_sys, .resetn, .apb_req(req), .prdata, .pready, .pslverr,
    .mode_pins, .init_flag_in, .init_flag_out(), .init_flag_oe_n,
    .cfg_done_in, .cfg_done_out(), .cfg_done_oe_n, .cfg_clk_out,
    .flash_select_a_n, .flash_select_b_n, .data_in, .data_out,
    .data_oe_n, .chain_data_out, .cfg_byte, .cfg_byte_valid
  );
  flash_model flash (
    .sck(cfg_clk_out), .cs_n(flash_select_a_n), .si(data_out[0]),
    .img, .so, .first_cmd, .last_cmd
  );
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, input logic [31:0] exp, input logic xerr);
    @(posedge clk_sys);
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    check(32'(pslverr), 32'(xerr));
    if (!wr) check(prdata, exp);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic pulse_reset(input logic [2:0] m);
    resetn <= 1'b0;
    mode_pins <= m;
    repeat (2) @(posedge clk_sys);
    check(32'({flash_select_a_n, cfg_done_oe_n}), 32'h2);
    resetn <= 1'b1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // delivered bytes compared against the oldest note
  always @(posedge clk_sys) begin
    if (cfg_byte_valid === 1'b1)
      check(32'(cfg_byte), expq.size() ? expq.pop_front() : 'x);
  end
  // cascade bit at each flash rise; rises 42..49 of a frame carry the
  // byte forwarded in the chain region
  always @(negedge flash_select_a_n or posedge cfg_clk_out) begin
    if (cfg_clk_out === 1'b1) begin
      if (nr >= 41 && nr <= 48) chain_sh = {chain_sh[6:0], chain_data_out};
      nr++;
    end else begin
      nr = 0;
    end
  end
  // hang guard, well above the two loads and the off-mode wait
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    resetn = 1'b0;
    req = '0;
    mode_pins = 3'b001;
    init_drv = 1'b0;
    st = 32'h934a;
    for (int i = 0; i < 5; i++) begin
      st = xs(st);
      rb[i] = st[7:0];
    end
    // chain byte ahead of own bytes: farthest device first
    img = {8'h5a, 8'h00, rb[0], rb[1], rb[2], rb[3], rb[4]};
    for (int i = 1; i < 5; i++) expq.push_back({24'h0, rb[i]});
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    apb(1'b1, `CL_A_CLK, 32'h1, 32'h0, 1'b0);
    apb(1'b0, `CL_A_CLK, 32'h0, 32'h4, 1'b0);
    apb(1'b1, `CL_A_CLK, 32'h8, 32'h0, 1'b0); // 160 ns flash clock
    apb(1'b0, `CL_A_CLK, 32'h0, 32'h8, 1'b0);
    apb(1'b1, `CL_A_CHAIN, 32'h1, 32'h0, 1'b0);
    apb(1'b0, `CL_A_LEN, 32'h0, 32'h4, 1'b0);
    apb(1'b0, 12'h100, 32'h0, 32'h0, 1'b1);
    check(32'(flash_select_a_n), 32'h1);
    init_drv <= 1'b1;
    while (cfg_done_oe_n !== 1'b1) @(posedge clk_sys);
    // let the byte watcher take the last note first
    @(posedge clk_sys);
    check(32'(chain_sh), 32'(rb[0]));
    check(first_cmd, {`CL_OP_X1, 24'h0});
    check(last_cmd, {`CL_OP_X1, 24'h2});
    check(32'({flash_select_a_n, flash_select_b_n}), 32'h3);
    check(32'(expq.size()), 32'h0);
    apb(1'b0, `CL_A_STAT, 32'h0, 32'h646, 1'b0);
    apb(1'b0, `CL_A_COUNT, 32'h0, 32'h4, 1'b0);
    pulse_reset(3'b000);
    repeat (100) @(posedge clk_sys);
    apb(1'b0, `CL_A_STAT, 32'h0, 32'h204, 1'b0);
    img[55:48] = 8'h00;
    pulse_reset(3'b001);
    while (init_flag_oe_n !== 1'b0) @(posedge clk_sys);
    apb(1'b0, `CL_A_STAT, 32'h0, 32'h47, 1'b0);
    tally_and_finish;
  end
endmodule

`default_nettype wire
